// ---- dbpm_pkg.sv ----
// Constants, types and register map of the dual port bus mux
package dbpm_pkg;

	localparam int DBPM_ADDR_W = 4;
	localparam int DBPM_DATA_W = 8;

	localparam logic [3:0] DBPM_OFS_LOW_PINS  = 4'h0;
	localparam logic [3:0] DBPM_OFS_LOW_LATCH = 4'h1;
	localparam logic [3:0] DBPM_OFS_LOW_DIR   = 4'h2;
	localparam logic [3:0] DBPM_OFS_HIGH_PINS = 4'h3;
	localparam logic [3:0] DBPM_OFS_HIGH_LAT  = 4'h4;
	localparam logic [3:0] DBPM_OFS_HIGH_DIR  = 4'h5;
	localparam logic [3:0] DBPM_OFS_SLAVE_CTL = 4'h6;
	localparam logic [3:0] DBPM_OFS_MEM_CTL   = 4'h7;

	localparam logic [7:0] DBPM_RST_DIR       = 8'hFF;
	localparam logic [7:0] DBPM_RST_LATCH     = 8'h00;
	localparam logic [7:0] DBPM_RST_SLAVE_CTL = 8'h00;
	localparam logic [7:0] DBPM_RST_MEM_CTL   = 8'h00;
	localparam logic [7:0] DBPM_MEM_CTL_MASK  = 8'hB3;
	localparam logic [7:0] DBPM_UNMAPPED_VAL  = 8'h00;

	localparam int DBPM_BIT_EXT_BUS_DIS = 7;
	localparam int DBPM_BIT_SLAVE_MODE  = 4;
	localparam int DBPM_BIT_OVERFLOW    = 5;
	localparam int DBPM_BIT_OUT_FULL    = 6;
	localparam int DBPM_BIT_IN_FULL     = 7;
	localparam int DBPM_CAPTURE_PIN     = 7;
	localparam logic [2:0] DBPM_SLAVE_CTL_PINS = 3'h7;

	typedef enum logic [1:0]
	{
		DBPM_MODE_MCU     = 2'h0,
		DBPM_MODE_EXT_MCU = 2'h1,
		DBPM_MODE_MPU     = 2'h3,
		DBPM_MODE_MPU_BT  = 2'h2
	} dbpm_prog_mode_type;

	typedef enum logic [1:0]
	{
		DBPM_OWN_GPIO  = 2'h0,
		DBPM_OWN_SLAVE = 2'h1,
		DBPM_OWN_BUS   = 2'h3
	} dbpm_owner_type;

	typedef struct packed
	{
		logic [7:0] dout;
		logic [7:0] oe;
	} dbpm_pins_type;

	typedef struct packed
	{
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} dbpm_reg_req_type;

endpackage

// ---- dbpm_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module dbpm_sync
	import dbpm_pkg::*;
#(
	parameter int WIDTH = 16
)
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin_async,
	output var  logic [WIDTH-1:0] pin_sync
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] stage3_ff;
	logic [WIDTH-1:0] value_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1_ff <= '0;
			stage2_ff <= '0;
			stage3_ff <= '0;
		end
		else
		begin
			stage1_ff <= pin_async;
			stage2_ff <= stage1_ff;
			stage3_ff <= stage2_ff;
		end
	end

	// Change counts only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++)
		begin : g_bit
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					value_ff[i] <= 1'b0;
				else if (stage2_ff[i] == stage3_ff[i])
					value_ff[i] <= stage3_ff[i];
			end
		end
	endgenerate

	assign pin_sync = value_ff;

endmodule
`default_nettype wire

// ---- dbpm_pin_mux.sv ----
// Per-pin selection between port latch and alternate function
`timescale 1ns/1ps
`default_nettype none
module dbpm_pin_mux
	import dbpm_pkg::*;
(
	input  wire logic [7:0]    latch,
	input  wire logic [7:0]    dir,
	input  wire logic [7:0]    alt_en,
	input  wire logic [7:0]    alt_out,
	input  wire logic [7:0]    alt_oe,
	output dbpm_pins_type      pins
);

	// Latch and direction are never overwritten by an owner
	genvar i;
	generate
		for (i = 0; i < 8; i++)
		begin : g_pin
			assign pins.dout[i] = alt_en[i] ? alt_out[i] : latch[i];
			assign pins.oe[i]   = alt_en[i] ? alt_oe[i] : ~dir[i];
		end
	endgenerate

endmodule
`default_nettype wire

// ---- dbpm_top.sv ----
// Dual bidirectional port with bus, slave port and capture muxing
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dbpm_top
	import dbpm_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic               warm_rst,
	input  wire logic [3:0]         reg_addr,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output var  logic [7:0]         reg_rdata,
	input  wire dbpm_prog_mode_type prog_mode,
	input  wire logic               pin_count_80,
	input  wire logic               alt_capture_pin_select,
	input  wire logic [7:0]         low_pin_in,
	output dbpm_pins_type           low_pins_o,
	input  wire logic [7:0]         high_pin_in,
	output dbpm_pins_type           high_pins_o,
	output var  logic               low_port_ttl,
	output var  logic               high_port_ttl,
	input  wire logic [15:0]        bus_ad_out,
	input  wire logic               bus_ad_oe,
	output var  logic [15:0]        bus_ad_in,
	input  wire logic [7:0]         slave_data_out,
	input  wire logic               slave_data_oe,
	output var  logic [7:0]         slave_data_in,
	output var  logic               slave_rd_n,
	output var  logic               slave_wr_n,
	output var  logic               slave_cs_n,
	input  wire logic               input_buffer_full,
	input  wire logic               output_buffer_full,
	input  wire logic               input_buffer_overflow,
	output var  logic               slave_port_active,
	input  wire logic               capture_out,
	input  wire logic               capture_oe,
	output var  logic               capture_in
);

	////////////////////////////////////////////////////////////////////////
	// Registers

	dbpm_reg_req_type req;
	logic [7:0]       low_latch_ff;
	logic [7:0]       low_dir_ff;
	logic [7:0]       high_latch_ff;
	logic [7:0]       high_dir_ff;
	logic             slave_mode_ff;
	logic [7:0]       mem_ctl_ff;
	logic [7:0]       reg_rdata_ff;
	logic [7:0]       nxt_rdata;
	logic [15:0]      pins_sync;
	logic [7:0]       low_sync;
	logic [7:0]       high_sync;
	logic             ext_bus_disable;
	logic             is_mcu;
	logic             high_bus_active;
	logic             low_bus_active;
	logic             slave_ctl_active;
	logic             capture_active;
	dbpm_owner_type   low_owner;
	dbpm_owner_type   high_owner;
	logic [7:0]       low_alt_en;
	logic [7:0]       low_alt_out;
	logic [7:0]       low_alt_oe;
	logic [7:0]       high_alt_en;
	logic [7:0]       high_alt_out;
	logic [7:0]       high_alt_oe;

	assign req.addr  = reg_addr;
	assign req.wdata = reg_wdata;
	assign req.wr    = reg_wr;
	assign req.rd    = reg_rd;

	// Writes are ignored during a warm reset so its hold is exact
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			low_dir_ff <= DBPM_RST_DIR;
		else if (req.wr && !warm_rst && req.addr == DBPM_OFS_LOW_DIR)
			low_dir_ff <= req.wdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			high_dir_ff <= DBPM_RST_DIR;
		else if (req.wr && !warm_rst && req.addr == DBPM_OFS_HIGH_DIR)
			high_dir_ff <= req.wdata;
	end

	// Pin level is unknown at power-on; zero is a safe pick
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			low_latch_ff <= DBPM_RST_LATCH;
		else if (req.wr && !warm_rst &&
			(req.addr == DBPM_OFS_LOW_LATCH || req.addr == DBPM_OFS_LOW_PINS))
			low_latch_ff <= req.wdata;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			high_latch_ff <= DBPM_RST_LATCH;
		else if (req.wr && !warm_rst &&
			(req.addr == DBPM_OFS_HIGH_LAT || req.addr == DBPM_OFS_HIGH_PINS))
			high_latch_ff <= req.wdata;
	end

	// Control registers do return to reset on a warm reset
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			slave_mode_ff <= DBPM_RST_SLAVE_CTL[DBPM_BIT_SLAVE_MODE];
		else if (warm_rst)
			slave_mode_ff <= DBPM_RST_SLAVE_CTL[DBPM_BIT_SLAVE_MODE];
		else if (req.wr && req.addr == DBPM_OFS_SLAVE_CTL)
			slave_mode_ff <= req.wdata[DBPM_BIT_SLAVE_MODE];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			mem_ctl_ff <= DBPM_RST_MEM_CTL;
		else if (warm_rst)
			mem_ctl_ff <= DBPM_RST_MEM_CTL;
		else if (req.wr && req.addr == DBPM_OFS_MEM_CTL)
			mem_ctl_ff <= req.wdata & DBPM_MEM_CTL_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	// Read path, data in the cycle after the strobe

	always_comb
	begin
		case (req.addr)
			DBPM_OFS_LOW_PINS:  nxt_rdata = low_sync;
			DBPM_OFS_LOW_LATCH: nxt_rdata = low_latch_ff;
			DBPM_OFS_LOW_DIR:   nxt_rdata = low_dir_ff;
			DBPM_OFS_HIGH_PINS: nxt_rdata = high_sync;
			DBPM_OFS_HIGH_LAT:  nxt_rdata = high_latch_ff;
			DBPM_OFS_HIGH_DIR:  nxt_rdata = high_dir_ff;
			DBPM_OFS_SLAVE_CTL: nxt_rdata = {input_buffer_full, output_buffer_full,
				input_buffer_overflow, slave_mode_ff, 4'h0};
			DBPM_OFS_MEM_CTL:   nxt_rdata = mem_ctl_ff;
			default:            nxt_rdata = DBPM_UNMAPPED_VAL;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata_ff <= 8'h00;
		else if (req.rd)
			reg_rdata_ff <= nxt_rdata;
		else
			reg_rdata_ff <= 8'h00;
	end

	assign reg_rdata = reg_rdata_ff;

	////////////////////////////////////////////////////////////////////////
	// Pin inputs

	dbpm_sync #(
		.WIDTH (16)
	) u_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_async ({high_pin_in, low_pin_in}),
		.pin_sync  (pins_sync)
	);

	assign low_sync      = pins_sync[7:0];
	assign high_sync     = pins_sync[15:8];
	assign bus_ad_in     = pins_sync;
	assign slave_data_in = low_sync;
	assign capture_in    = high_sync[DBPM_CAPTURE_PIN];

	////////////////////////////////////////////////////////////////////////
	// Ownership

	assign ext_bus_disable  = mem_ctl_ff[DBPM_BIT_EXT_BUS_DIS];
	assign is_mcu           = (prog_mode == DBPM_MODE_MCU);
	assign low_bus_active   = !ext_bus_disable;
	// Bus high byte needs the 80-pin part outside controller mode
	assign high_bus_active  = !ext_bus_disable && !is_mcu && pin_count_80;
	assign slave_port_active = slave_mode_ff && !low_bus_active;
	assign slave_ctl_active = slave_mode_ff && is_mcu && !high_bus_active;
	assign capture_active   = is_mcu && !alt_capture_pin_select && !high_bus_active;

	always_comb
	begin
		if (low_bus_active)
			low_owner = DBPM_OWN_BUS;
		else if (slave_mode_ff)
			low_owner = DBPM_OWN_SLAVE;
		else
			low_owner = DBPM_OWN_GPIO;
	end

	always_comb
	begin
		if (high_bus_active)
			high_owner = DBPM_OWN_BUS;
		else if (slave_ctl_active)
			high_owner = DBPM_OWN_SLAVE;
		else
			high_owner = DBPM_OWN_GPIO;
	end

	// Low port alternate drive
	always_comb
	begin
		case (low_owner)
			DBPM_OWN_BUS:
			begin
				low_alt_en  = 8'hFF;
				low_alt_out = bus_ad_out[7:0];
				low_alt_oe  = {8{bus_ad_oe}};
			end
			DBPM_OWN_SLAVE:
			begin
				low_alt_en  = 8'hFF;
				low_alt_out = slave_data_out;
				low_alt_oe  = {8{slave_data_oe}};
			end
			default:
			begin
				low_alt_en  = 8'h00;
				low_alt_out = 8'h00;
				low_alt_oe  = 8'h00;
			end
		endcase
	end

	// High port alternate drive; slave controls are inputs only
	always_comb
	begin
		high_alt_en  = 8'h00;
		high_alt_out = 8'h00;
		high_alt_oe  = 8'h00;
		case (high_owner)
			DBPM_OWN_BUS:
			begin
				high_alt_en  = 8'hFF;
				high_alt_out = bus_ad_out[15:8];
				high_alt_oe  = {8{bus_ad_oe}};
			end
			DBPM_OWN_SLAVE:
			begin
				high_alt_en[2:0] = DBPM_SLAVE_CTL_PINS;
			end
			default:
			begin
				high_alt_en = 8'h00;
			end
		endcase
		if (capture_active)
		begin
			high_alt_en[DBPM_CAPTURE_PIN]  = 1'b1;
			high_alt_out[DBPM_CAPTURE_PIN] = capture_out;
			high_alt_oe[DBPM_CAPTURE_PIN]  = capture_oe;
		end
	end

	// Control strobes idle high unless the slave owns the pins
	assign slave_rd_n = slave_ctl_active ? high_sync[0] : 1'b1;
	assign slave_wr_n = slave_ctl_active ? high_sync[1] : 1'b1;
	assign slave_cs_n = slave_ctl_active ? high_sync[2] : 1'b1;

	assign low_port_ttl  = (low_owner != DBPM_OWN_GPIO);
	assign high_port_ttl = (high_owner != DBPM_OWN_GPIO);

	dbpm_pin_mux u_low_mux (
		.latch   (low_latch_ff),
		.dir     (low_dir_ff),
		.alt_en  (low_alt_en),
		.alt_out (low_alt_out),
		.alt_oe  (low_alt_oe),
		.pins    (low_pins_o)
	);

	dbpm_pin_mux u_high_mux (
		.latch   (high_latch_ff),
		.dir     (high_dir_ff),
		.alt_en  (high_alt_en),
		.alt_out (high_alt_out),
		.alt_oe  (high_alt_oe),
		.pins    (high_pins_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_input_hiz_dir: assert property (
		(low_owner == DBPM_OWN_GPIO) |-> ((low_pins_o.oe & low_dir_ff) == 8'h00))
		else $error("input pin driven");

	a_output_from_latch: assert property (
		(low_owner == DBPM_OWN_GPIO) |->
		((low_pins_o.dout & ~low_dir_ff) == (low_latch_ff & ~low_dir_ff))
		&& ((low_pins_o.oe | low_dir_ff) == 8'hFF))
		else $error("output pin not latch");

	a_latch_readback: assert property (
		(req.rd && req.addr == DBPM_OFS_LOW_LATCH) |=> (reg_rdata == $past(low_latch_ff)))
		else $error("latch read wrong");

	a_pins_write_latch: assert property (
		(req.wr && !warm_rst && req.addr == DBPM_OFS_HIGH_PINS) |=> (high_latch_ff == $past(req.wdata)))
		else $error("pins write lost");

	a_high_latch_read: assert property (
		(req.rd && req.addr == DBPM_OFS_HIGH_LAT) |=> (reg_rdata == $past(high_latch_ff)))
		else $error("high latch read wrong");

	a_pins_read_level: assert property (
		(req.rd && req.addr == DBPM_OFS_LOW_PINS) |=> (reg_rdata == $past(low_sync)))
		else $error("pins read wrong");

	a_por_dir_set: assert property (
		$rose(rst_n) |-> (low_dir_ff == DBPM_RST_DIR && high_dir_ff == DBPM_RST_DIR))
		else $error("direction not set at reset");

	a_warm_keeps_regs: assert property (
		warm_rst |=> ($stable(low_dir_ff) && $stable(low_latch_ff)
		&& $stable(high_dir_ff) && $stable(high_latch_ff)))
		else $error("warm reset changed port");

	a_bus_owns_low: assert property (
		!mem_ctl_ff[DBPM_BIT_EXT_BUS_DIS] |->
		(low_pins_o.dout == bus_ad_out[7:0] && low_pins_o.oe == {8{bus_ad_oe}} && low_port_ttl))
		else $error("bus not on low port");

	a_slave_ctl_inputs: assert property (
		(slave_mode_ff && is_mcu && !high_bus_active) |->
		(high_pins_o.oe[2:0] == 3'h0 && slave_cs_n == high_sync[2]))
		else $error("slave controls driven");

	a_capture_top_pin: assert property (
		(is_mcu && !alt_capture_pin_select && !high_bus_active) |->
		(high_pins_o.dout[DBPM_CAPTURE_PIN] == capture_out
		&& high_pins_o.oe[DBPM_CAPTURE_PIN] == capture_oe))
		else $error("capture pin not routed");

	a_high_bus_por: assert property (
		($rose(rst_n) && !is_mcu && pin_count_80) |-> (high_owner == DBPM_OWN_BUS))
		else $error("high port not bus after reset");

	a_bus_priority: assert property (
		(slave_mode_ff && !ext_bus_disable) |-> (low_owner == DBPM_OWN_BUS && !slave_port_active))
		else $error("slave beat bus");

endmodule
`default_nettype wire

// ---- dbpm_pin_partner.sv ----
// Far-side pin model: resolves each pad from device drive and external drive
`timescale 1ns/1ps
`default_nettype none
module dbpm_pin_partner
	import dbpm_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire dbpm_pins_type pins,
	input  wire logic [7:0]    ext_val,
	input  wire logic [7:0]    ext_oe,
	output var  logic [7:0]    pad_lvl
);
	////////////////////////////////////////////////////////////////////////
	logic flt_ff;

	// No pull resistors: an undriven pad wanders, so stale values never pass
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flt_ff <= 1'b0;
		else
			flt_ff <= ~flt_ff;
	end

	// Device drive wins; a released pad shows the outside or the float pattern
	assign pad_lvl = (pins.oe & pins.dout) | (~pins.oe & ext_oe & ext_val)
		| (~pins.oe & ~ext_oe & ({8{flt_ff}} ^ 8'h55));
endmodule
`default_nettype wire

// ---- dbpm_top_tb.sv ----
// Self-checking bench for the dual port bus mux
`timescale 1ns/1ps
`default_nettype none
module dbpm_top_tb;
	import dbpm_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, warm_rst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, low_pin_in, high_pin_in, slave_data_out = 8'h00, slave_data_in;
	dbpm_prog_mode_type prog_mode = DBPM_MODE_MPU;
	logic pin_count_80 = 1'b1, alt_capture_pin_select = 1'b0, bus_ad_oe = 1'b0, slave_data_oe = 1'b0;
	logic input_buffer_full = 1'b1, output_buffer_full = 1'b0, input_buffer_overflow = 1'b1;
	logic capture_out = 1'b0, capture_oe = 1'b0, capture_in, low_port_ttl, high_port_ttl;
	logic slave_rd_n, slave_wr_n, slave_cs_n, slave_port_active;
	logic [15:0] bus_ad_out = 16'h0000, bus_ad_in;
	logic [7:0] low_ext = 8'h00, high_ext = 8'h00, low_ext_oe = 8'h00, high_ext_oe = 8'h00;
	dbpm_pins_type low_pins_o, high_pins_o, pv;
	logic [7:0] exp_q[$];
	logic [7:0] lv, ev, sd;
	integer seed = 32'hA4775DFE;
	integer miscompares = 0, check_count = 0;

	////////////////////////////////////////////////////////////////////////
	always #50 clk = ~clk;

	dbpm_top DUT (.clk, .rst_n, .warm_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.prog_mode, .pin_count_80, .alt_capture_pin_select, .low_pin_in, .low_pins_o, .high_pin_in,
		.high_pins_o, .low_port_ttl, .high_port_ttl, .bus_ad_out, .bus_ad_oe, .bus_ad_in,
		.slave_data_out, .slave_data_oe, .slave_data_in, .slave_rd_n, .slave_wr_n, .slave_cs_n,
		.input_buffer_full, .output_buffer_full, .input_buffer_overflow, .slave_port_active,
		.capture_out, .capture_oe, .capture_in);
	dbpm_pin_partner low_pad (.clk, .rst_n, .pins(low_pins_o), .ext_val(low_ext), .ext_oe(low_ext_oe),
		.pad_lvl(low_pin_in));
	dbpm_pin_partner high_pad (.clk, .rst_n, .pins(high_pins_o), .ext_val(high_ext), .ext_oe(high_ext_oe),
		.pad_lvl(high_pin_in));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		check_count++;
		if (seen !== expv)
		begin
			miscompares++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask

	task automatic end_of_test();
		$display("miscompares=%0d check_count=%0d", miscompares, check_count);
		if (miscompares == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Strobes stay up so accesses can run back to back; idle drops them
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_rd <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] expv);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_wr <= 1'b0;
		reg_addr <= a;
		exp_q.push_back(expv);
	endtask

	task automatic idle(input int n);
		repeat (n)
		begin
			@(posedge clk);
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
		end
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Read data stands only in the cycle after the strobe
	always @(posedge clk)
		rd_d <= reg_rd;

	always @(negedge clk)
	begin
		if (rd_d)
		begin
			if (exp_q.size() == 0)
				miscompares++;
			else
				check(reg_rdata, exp_q.pop_front());
		end
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		bus_ad_out <= 16'($random(seed));
		bus_ad_oe <= 1'b1;
		rd(4'h2, DBPM_RST_DIR);
		rd(4'h5, DBPM_RST_DIR);
		rd(4'h6, 8'hA0);
		rd(4'h7, 8'h00);
		idle(2);
		check(low_pins_o.dout, bus_ad_out[7:0]);
		check(low_pins_o.oe, 8'hFF);
		check(high_pins_o.dout, bus_ad_out[15:8]);
		check(low_port_ttl, 1'b1);
		bus_ad_oe <= 1'b0;
		{high_ext, low_ext} <= 16'($random(seed));
		{high_ext_oe, low_ext_oe} <= 16'hFFFF;
		idle(6);
		check(bus_ad_in, {high_ext, low_ext});
		bus_ad_oe <= 1'b1;
		for (int m = 0; m < 4; m++)
		begin
			prog_mode <= dbpm_prog_mode_type'(m);
			idle(1);
			check(high_port_ttl, prog_mode != DBPM_MODE_MCU);
		end
		pin_count_80 <= 1'b0;
		idle(1);
		check(high_port_ttl, 1'b0);
		wr(4'h7, 8'hFF);
		rd(4'h7, 8'hFF & DBPM_MEM_CTL_MASK);
		wr(4'hA, 8'h3C);
		rd(4'hA, DBPM_UNMAPPED_VAL);
		idle(1);
		check(low_port_ttl, 1'b0);
		for (int p = 0; p < 2; p++)
		begin
			lv = 8'($random(seed));
			ev = 8'($random(seed));
			if (p == 0)
				low_ext <= ev;
			else
				high_ext <= ev;
			wr(4'(p * 3 + 1), lv);
			wr(4'(p * 3 + 2), 8'h0F);
			idle(1);
			pv = (p == 0) ? low_pins_o : high_pins_o;
			check(pv.oe, 8'hF0);
			check(pv.dout & 8'hF0, lv & 8'hF0);
			idle(6);
			rd(4'(p * 3 + 1), lv);
			rd(4'(p * 3), (lv & 8'hF0) | (ev & 8'h0F));
			wr(4'(p * 3), ~lv);
			rd(4'(p * 3 + 1), ~lv);
		end
		wr(4'h1, 8'h5A);
		wr(4'h2, 8'hC3);
		idle(1);
		warm_rst <= 1'b1;
		idle(1);
		warm_rst <= 1'b0;
		rd(4'h7, 8'h00);
		rd(4'h1, 8'h5A);
		rd(4'h2, 8'hC3);
		prog_mode <= DBPM_MODE_MCU;
		sd = 8'($random(seed));
		slave_data_out <= sd;
		slave_data_oe <= 1'b1;
		high_ext <= 8'h02;
		wr(4'h7, 8'h80);
		wr(4'h6, 8'h1F);
		wr(4'h5, 8'h07);
		idle(6);
		check(slave_port_active, 1'b1);
		check(low_pins_o.oe, 8'hFF);
		check(low_pins_o.dout, sd);
		check(low_port_ttl, 1'b1);
		check(high_pins_o.oe & 8'h07, 8'h00);
		check({slave_cs_n, slave_wr_n, slave_rd_n}, 3'b010);
		check(slave_data_in, sd);
		rd(4'h6, 8'hB0);
		rd(4'h1, 8'h5A);
		wr(4'h7, 8'h00);
		idle(1);
		check(slave_port_active, 1'b0);
		check(low_pins_o.dout, bus_ad_out[7:0]);
		wr(4'h6, 8'h00);
		wr(4'h7, 8'h80);
		wr(4'h5, 8'hFF);
		capture_oe <= 1'b1;
		for (int c = 0; c < 2; c++)
		begin
			capture_out <= c[0];
			idle(5);
			check(capture_in, c[0]);
			check(high_pins_o.oe[7], 1'b1);
			check(high_pins_o.dout[7], c[0]);
		end
		alt_capture_pin_select <= 1'b1;
		idle(1);
		check(high_pins_o.oe[7], 1'b0);
		idle(2);
		check({slave_cs_n, slave_wr_n, slave_rd_n}, 3'b111);
		if (exp_q.size() != 0)
			miscompares++;
		end_of_test();
	end
endmodule
`default_nettype wire
